/* File: core/open_loop_startup_commutator.sv */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module open_loop_startup_commutator
  import startup_pkg::*;
#(
  parameter int PWM_PERIOD = 1000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [5:0] o_pwm,
  output logic [2:0] o_commutation_index,
  output logic o_advance_trigger,
  output logic [15:0] o_ramp_finished_flag
);
  typedef struct packed {
    logic run;
    logic [PERIOD_W-1:0] initial_period_setting;
    logic [PERIOD_W-1:0] final_period_setting;
    logic [DELAY_W-1:0] step_interval_setting;
    logic [DUTY_W-1:0] startup_duty;
    logic [15:0] tick_div;
    logic [31:0] rdata;
    ramp_state_e state;
    logic [15:0] tick_cnt;
    logic tick;
    logic [DELAY_W-1:0] delay_cnt;
    logic [PERIOD_W-1:0] period;
    logic [15:0] ramp_finished_flag;
    logic [PERIOD_W-1:0] pulse_cnt;
    logic trigger;
    logic [2:0] six_state_counter;
    logic [15:0] carrier;
  } core_s;
  core_s q;
  core_s next_q;

  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [5:0] pattern;
  logic [5:0] leg_en;

  assign wr_en = psel && penable && pwrite;
  // read data is fetched in the setup cycle so it stands during the access
  assign rd_en = psel && !penable && !pwrite;
  assign mapped = (paddr == OFS_CONTROL) || (paddr == OFS_INIT_PERIOD) ||
                  (paddr == OFS_FINAL_PERIOD) || (paddr == OFS_STEP_DELAY) ||
                  (paddr == OFS_DUTY) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_TICK_DIV);

  // merge byte lanes into a 16-bit field
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // commutation table: bits are {c_lo,c_hi,b_lo,b_hi,a_lo,a_hi}
  always_comb begin
    case (q.six_state_counter)
      3'h0: pattern = 6'h09; // a high, b low
      3'h1: pattern = 6'h21; // a high, c low
      3'h2: pattern = 6'h24; // b high, c low
      3'h3: pattern = 6'h06; // b high, a low
      3'h4: pattern = 6'h12; // c high, a low
      3'h5: pattern = 6'h18; // c high, b low
      default: pattern = 6'h00;
    endcase
  end
  assign leg_en = q.run ? pattern : 6'h00;

  // next-state logic: bus, tick, ramp, pulse, counter, carrier
  always_comb begin
    next_q = q;
    // register writes
    if (wr_en) begin
      case (paddr)
        OFS_CONTROL: begin
          if (pstrb[0]) begin
            next_q.run = pwdata[CTRL_RUN_BIT];
          end
        end
        OFS_INIT_PERIOD: next_q.initial_period_setting =
          lane16(q.initial_period_setting, pwdata, pstrb);
        OFS_FINAL_PERIOD: next_q.final_period_setting =
          lane16(q.final_period_setting, pwdata, pstrb);
        OFS_STEP_DELAY: next_q.step_interval_setting =
          lane16(q.step_interval_setting, pwdata, pstrb);
        OFS_DUTY: next_q.startup_duty =
          lane16(q.startup_duty, pwdata, pstrb);
        OFS_TICK_DIV: next_q.tick_div = lane16(q.tick_div, pwdata, pstrb);
        default: ;
      endcase
    end
    // register reads
    next_q.rdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        OFS_CONTROL: next_q.rdata = {31'h0, q.run};
        OFS_INIT_PERIOD: next_q.rdata = {16'h0, q.initial_period_setting};
        OFS_FINAL_PERIOD: next_q.rdata = {16'h0, q.final_period_setting};
        OFS_STEP_DELAY: next_q.rdata = {16'h0, q.step_interval_setting};
        OFS_DUTY: next_q.rdata = {16'h0, q.startup_duty};
        OFS_STATUS: next_q.rdata = {q.ramp_finished_flag, 10'h0,
                                    q.six_state_counter, q.state == ST_HOLD,
                                    q.state == ST_RAMP, q.run};
        OFS_TICK_DIV: next_q.rdata = {16'h0, q.tick_div};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    // sampling tick prescaler
    next_q.tick = 1'b0;
    if (q.tick_cnt >= q.tick_div) begin
      next_q.tick_cnt = 16'h0000;
      next_q.tick = 1'b1;
    end else begin
      next_q.tick_cnt = q.tick_cnt + 16'h0001;
    end
    // ramp down generator
    case (q.state)
      ST_IDLE: begin
        next_q.period = q.initial_period_setting;
        next_q.delay_cnt = '0;
        next_q.ramp_finished_flag = 16'h0000;
        if (q.run) begin
          next_q.state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (q.period <= q.final_period_setting) begin
          next_q.state = ST_HOLD;
          next_q.ramp_finished_flag = RAMP_DONE_VALUE;
        end else if (q.tick) begin
          if (q.delay_cnt >= q.step_interval_setting) begin
            next_q.delay_cnt = '0;
            next_q.period = q.period - 16'h0001;
          end else begin
            next_q.delay_cnt = q.delay_cnt + 16'h0001;
          end
        end
      end
      ST_HOLD: begin
        next_q.ramp_finished_flag = RAMP_DONE_VALUE;
      end
      default: next_q.state = ST_IDLE;
    endcase
    if (!q.run) begin
      next_q.state = ST_IDLE;
    end
    // impulse generator, counted in sampling ticks
    next_q.trigger = 1'b0;
    if (q.state == ST_IDLE) begin
      next_q.pulse_cnt = '0;
    end else if (q.tick) begin
      if (q.pulse_cnt + 16'h0001 >= q.period) begin
        next_q.pulse_cnt = '0;
        next_q.trigger = 1'b1;
      end else begin
        next_q.pulse_cnt = q.pulse_cnt + 16'h0001;
      end
    end
    // six-state commutation counter
    if (q.trigger) begin
      if (q.six_state_counter >= LAST_INDEX) begin
        next_q.six_state_counter = 3'h0;
      end else begin
        next_q.six_state_counter = q.six_state_counter + 3'h1;
      end
    end
    // pwm carrier sawtooth
    if (q.carrier >= 16'(PWM_PERIOD - 1)) begin
      next_q.carrier = 16'h0000;
    end else begin
      next_q.carrier = q.carrier + 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
      q.initial_period_setting <= RST_INIT_PERIOD;
      q.final_period_setting <= RST_FINAL_PERIOD;
      q.step_interval_setting <= RST_STEP_DELAY;
      q.startup_duty <= RST_DUTY;
      q.tick_div <= RST_TICK_DIV;
      q.state <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // one channel per switch
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_leg
      pwm_leg #(.W(16)) u_leg (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_enable(leg_en[g]),
        .i_carrier(q.carrier),
        .i_duty(q.startup_duty),
        .o_pwm(o_pwm[g])
      );
    end
  endgenerate

  // bus answers
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = q.rdata;
  assign o_commutation_index = q.six_state_counter;
  assign o_advance_trigger = q.trigger;
  assign o_ramp_finished_flag = q.ramp_finished_flag;

  property p_index_range;
    @(posedge i_core_clk) disable iff (i_rst)
      q.six_state_counter <= LAST_INDEX;
  endproperty
  a_index_range: assert property (p_index_range)
    else $error("index out of range");

  property p_wrap;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.trigger && q.six_state_counter == 3'h5) |=>
        q.six_state_counter == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap");

  property p_advance;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.trigger && q.six_state_counter < 3'h5) |=>
        q.six_state_counter == $past(q.six_state_counter) + 3'h1;
  endproperty
  a_advance: assert property (p_advance)
    else $error("counter did not advance");

  property p_hold_idx;
    @(posedge i_core_clk) disable iff (i_rst)
      !q.trigger |=> $stable(q.six_state_counter);
  endproperty
  a_hold_idx: assert property (p_hold_idx)
    else $error("counter moved without trigger");

  property p_done_flag;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.state == ST_RAMP && q.period <= q.final_period_setting) |=>
        q.ramp_finished_flag == 16'h7FFF;
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("done flag not set");

  property p_step_one;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.state == ST_RAMP && q.run && q.period != $past(q.period)) |->
        q.period == $past(q.period) - 16'h0001;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("ramp step not one");

  property p_load;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.state == ST_IDLE) |=> q.period == $past(q.initial_period_setting);
  endproperty
  a_load: assert property (p_load)
    else $error("period not loaded");

  property p_pulse_single;
    @(posedge i_core_clk) disable iff (i_rst)
      q.trigger |=> !q.trigger;
  endproperty
  a_pulse_single: assert property (p_pulse_single)
    else $error("trigger longer than one cycle");

  property p_outputs_pattern;
    @(posedge i_core_clk) disable iff (i_rst)
      ((o_pwm & ~$past(leg_en)) == 6'h00);
  endproperty
  a_outputs_pattern: assert property (p_outputs_pattern)
    else $error("pwm outside pattern");

  property p_flag_values;
    @(posedge i_core_clk) disable iff (i_rst)
      (q.ramp_finished_flag == 16'h0000) ||
      (q.ramp_finished_flag == RAMP_DONE_VALUE);
  endproperty
  a_flag_values: assert property (p_flag_values)
    else $error("done flag holds an odd value");

  property p_idle_dark;
    @(posedge i_core_clk) disable iff (i_rst)
      !q.run |=> o_pwm == 6'h00;
  endproperty
  a_idle_dark: assert property (p_idle_dark)
    else $error("pwm active while stopped");
endmodule

/* File: include/startup_pkg.sv */
// Behaviour
// - ramp period falls over time from start value toward target
// - fall rate set by programmable ramp step delay
// - on start the period loads from the initial setting
// - at target the period holds and finished flag reads 0x7FFF
// - pulse generator fires one pulse per current period
// - six-state counter holds only values 0 through 5
// - counter advances on each trigger pulse, else holds
// - counter value picks one of six inverter switch patterns
// - active outputs run at the start-up duty setting
// - ramp length follows delay, tick period and period difference
package startup_pkg;
  localparam int PERIOD_W = 16;
  localparam int DELAY_W = 16;
  localparam int DUTY_W = 16;
  localparam int PADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] OFS_CONTROL = 12'h000;
  localparam logic [11:0] OFS_INIT_PERIOD = 12'h004;
  localparam logic [11:0] OFS_FINAL_PERIOD = 12'h008;
  localparam logic [11:0] OFS_STEP_DELAY = 12'h00C;
  localparam logic [11:0] OFS_DUTY = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_TICK_DIV = 12'h018;
  // control fields
  localparam int CTRL_RUN_BIT = 0;
  // reset values
  localparam logic [15:0] RST_INIT_PERIOD = 16'h0100;
  localparam logic [15:0] RST_FINAL_PERIOD = 16'h0040;
  localparam logic [15:0] RST_STEP_DELAY = 16'h0004;
  localparam logic [15:0] RST_DUTY = 16'h1000;
  localparam logic [15:0] RST_TICK_DIV = 16'h007C;
  localparam logic [15:0] RAMP_DONE_VALUE = 16'h7FFF;
  localparam logic [2:0] LAST_INDEX = 3'h5;
  typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD} ramp_state_e;
endpackage

/* File: core/pwm_leg.sv */
`timescale 1ns/1ps
// one pwm channel: on while enabled and the carrier is below duty
module pwm_leg
  import startup_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic [W-1:0] i_carrier,
  input wire logic [W-1:0] i_duty,
  output logic o_pwm
);
  typedef struct packed {
    logic pwm;
  } leg_s;
  leg_s q;
  leg_s next_q;

  // compare carrier with duty
  always_comb begin
    next_q = q;
    next_q.pwm = i_enable && (i_carrier < i_duty);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_pwm = q.pwm;
endmodule

/* File: dv/inverter_model.sv */
`timescale 1ns/1ps
// inverter legs: a leg drives its phase with one switch on, else it floats
module inverter_model (
  input wire logic i_core_clk,
  input wire logic [5:0] i_gate,
  output logic [2:0] o_phase_on,
  output logic [2:0] o_phase_lvl,
  output logic o_shoot
);
  logic wobble = 1'b0;
  // a floating phase shows a level that changes every cycle
  always @(posedge i_core_clk) wobble <= !wobble;
  // both switches of one leg on shorts the bus
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      o_phase_on[k] = i_gate[2*k] ^ i_gate[2*k+1];
      o_phase_lvl[k] = o_phase_on[k] ? i_gate[2*k] : wobble;
    end
    o_shoot = |({i_gate[4], i_gate[2], i_gate[0]} &
      {i_gate[5], i_gate[3], i_gate[1]});
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
  import startup_pkg::*;
  logic i_core_clk = 0;
  logic i_rst = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, o_advance_trigger, o_shoot;
  logic [5:0] o_pwm;
  logic [2:0] o_commutation_index, o_phase_on, last_idx = '0;
  logic [15:0] o_ramp_finished_flag, ini, fin, dly, dut;
  logic [31:0] exp_q[$];
  logic [5:0] pat[6];
  logic mon_on = 0;
  logic [2:0] o_phase_lvl;
  logic [5:0] hi_legs;
  int failures = 0, samples_checked = 0, seed, n, et, since_trig = 0;
  // clock at 125 MHz
  always #4 i_core_clk = !i_core_clk;
  open_loop_startup_commutator #(.PWM_PERIOD(16)) dut_u (.i_core_clk,
    .i_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .o_pwm, .o_commutation_index, .o_advance_trigger,
    .o_ramp_finished_flag);
  inverter_model inv_u (.i_core_clk, .i_gate(o_pwm),
    .o_phase_on(o_phase_on), .o_phase_lvl(o_phase_lvl), .o_shoot(o_shoot));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("counts: %0d checked, %0d failed", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one apb transfer; a read notes its expected data in the queue
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic err);
    int k;
    @(posedge i_core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h3;
    if (!w) exp_q.push_back(d);
    @(posedge i_core_clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge i_core_clk);
      if (++k > 50) begin
        failures++;
        wrap_up();
      end
    end while (pready !== 1'b1);
    chk(pslverr, err);
    psel <= 0;
    penable <= 0;
  endtask
  // waits for the next trigger, returns cycles waited
  task automatic wait_trig(output int c);
    @(posedge i_core_clk);
    c = 1;
    while (o_advance_trigger !== 1'b1) begin
      @(posedge i_core_clk);
      if (++c > 3000) begin
        failures++;
        wrap_up();
      end
    end
  endtask
  // read data taken at the access edge with pready; index and leg watch
  always @(posedge i_core_clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(1, 0);
      else chk(prdata, exp_q.pop_front());
    end
    if (mon_on) begin
      chk(o_commutation_index < 3'h6, 1);
      chk(o_shoot, 0);
      if (o_commutation_index !== last_idx) begin
        chk(o_commutation_index, last_idx == LAST_INDEX ? 0 : last_idx + 1);
        chk(since_trig < 4, 1);
        last_idx <= o_commutation_index;
      end
      since_trig <= o_advance_trigger ? 0 : since_trig + 1;
    end
  end
  initial begin
    seed = 52785;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 0;
    mon_on <= 1;
    apb(0, OFS_INIT_PERIOD, RST_INIT_PERIOD, 0);
    apb(0, OFS_FINAL_PERIOD, RST_FINAL_PERIOD, 0);
    apb(0, OFS_STEP_DELAY, RST_STEP_DELAY, 0);
    apb(0, OFS_DUTY, RST_DUTY, 0);
    apb(0, OFS_TICK_DIV, RST_TICK_DIV, 0);
    apb(0, OFS_STATUS, 0, 0);
    apb(1, 12'h01C, 32'h0000FFFF, 1);
    apb(0, 12'h01C, 0, 1);
    apb(0, OFS_CONTROL, 0, 0);
    $display("test reset_and_map done");
    ini = 16'd24 + ($random(seed) & 15);
    fin = ini - 16'd3 - ($random(seed) & 3);
    dly = $random(seed) & 3;
    apb(1, OFS_TICK_DIV, 1, 0);
    apb(1, OFS_INIT_PERIOD, ini, 0);
    apb(1, OFS_FINAL_PERIOD, fin, 0);
    apb(1, OFS_STEP_DELAY, dly, 0);
    apb(1, OFS_DUTY, 32'h0000FFFF, 0);
    apb(0, OFS_INIT_PERIOD, ini, 0);
    apb(1, OFS_CONTROL, 1, 0);
    n = 0;
    while (o_ramp_finished_flag !== RAMP_DONE_VALUE && n < 5000) begin
      @(posedge i_core_clk);
      n++;
    end
    et = (ini - fin) * (dly + 1) * 2;
    chk(o_ramp_finished_flag, RAMP_DONE_VALUE);
    chk(n >= et - 2 * dly - 6 && n <= et + 2 * dly + 6, 1);
    wait_trig(n);
    wait_trig(n);
    chk(n, fin * 2);
    wait_trig(n);
    chk(n, fin * 2);
    $display("test ramp_and_spacing done");
    for (int k = 0; k < 8; k++) begin
      wait_trig(n);
      repeat (3) @(posedge i_core_clk);
      pat[o_commutation_index] = o_pwm;
      chk($countones(o_pwm), 2);
      chk($countones(o_phase_on), 2);
      chk($countones(o_phase_lvl & o_phase_on), 1);
    end
    for (int i = 0; i < 6; i++)
      for (int j = i + 1; j < 6; j++)
        chk(pat[i] !== pat[j], 1);
    $display("test six_patterns done");
    dut = 16'd1 + ($random(seed) & 14);
    apb(1, OFS_DUTY, dut, 0);
    wait_trig(n);
    repeat (3) @(posedge i_core_clk);
    hi_legs = pat[o_commutation_index] & 6'h15;
    n = 0;
    repeat (16) begin
      @(posedge i_core_clk);
      n += |(o_pwm & hi_legs);
    end
    chk(n, dut);
    $display("test startup_duty done");
    mon_on <= 0;
    apb(1, OFS_CONTROL, 0, 0);
    repeat (3) @(posedge i_core_clk);
    chk(o_ramp_finished_flag, 0);
    $display("test stop done");
    wrap_up();
  end
endmodule
